// ---- clk_src_model.sv ----
// Far-side clock sources and the external master clock device
`timescale 1ns/100ps
module clk_src_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Master clock pin as driven by the block
  input  wire logic pinOeN,
  input  wire logic pinOut,
  // Source and pin levels
  output logic      oscLvl,
  output logic      pllALvl,
  output logic      pllBLvl,
  output logic      pinLvl
);
  logic [3:0] cnt_reg;
  logic [2:0] six_reg;
  // Free-running dividers, every level high two cycles or more
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      six_reg <= 3'h0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      six_reg <= (six_reg == 3'h5) ? 3'h0 : six_reg + 3'h1;
    end
  end
  // Source levels
  assign oscLvl  = cnt_reg[1];
  assign pllALvl = cnt_reg[2];
  assign pllBLvl = six_reg > 3'h2;
  // External clock only while the block releases the pin
  assign pinLvl = pinOeN ? cnt_reg[3] : pinOut;
endmodule : clk_src_model

// ---- dual_pll_clk_pkg.sv ----
// Constants, types and register map of the dual PLL clock block
// Summary of operation
// - PLL ratio is integer plus fraction/2^22
// - Both PLLs share one identical structure
// - Master pin select: input, A, B, oscillator
// - Aux pin select: tristate, A, B, oscillator
// - Receive mode: receiver drives PLL A multipliers
// - Receiver picks high, mid or 32k mode
// - Receive mode ignores PLL B output divider bits
// - Reset values suit a 12 MHz crystal
// - Output divider 2/4/8/12, doubled when set
// - Pre-divider passes or halves the oscillator
package dual_pll_clk_pkg;

  // Register port, field and receiver rate widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 9;
  localparam int FRAC_W = 22;
  localparam int INT_W  = 4;
  localparam int FS_W   = 17;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_A_K_LO  = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_A_K_MID = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_A_N     = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_A_CTRL  = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_B_K_LO  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_B_K_MID = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_B_N     = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_B_CTRL  = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_MODE    = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 4'h9;

  // Field positions
  localparam int PREDIV_BIT = 0;
  localparam int DOUBLE_BIT = 1;
  localparam int RANGE_LSB  = 3;
  localparam int MPIN_LSB   = 5;
  localparam int APIN_LSB   = 7;
  localparam int N_LSB      = 4;
  localparam int RXEN_BIT   = 0;

  // Reset values
  localparam logic              RST_PREDIV = 1'h0;
  localparam logic [INT_W-1:0]  RST_INT    = 4'h7;
  localparam logic [FRAC_W-1:0] RST_FRAC   = 22'h36fd21;
  localparam logic [1:0]        RST_RANGE  = 2'h2;
  localparam logic              RST_DOUBLE = 1'h0;
  localparam logic [1:0]        RST_MPIN   = 2'h0;
  localparam logic [1:0]        RST_APIN   = 2'h3;

  // Output divider base factors per range code
  localparam logic [4:0] DIV_R0 = 5'h02;
  localparam logic [4:0] DIV_R1 = 5'h04;
  localparam logic [4:0] DIV_R2 = 5'h08;
  localparam logic [4:0] DIV_R3 = 5'h0c;

  // Receiver sample rate windows in Hz, 1 percent tolerance
  localparam int TOL_PCT  = 1;
  localparam int FS_LO_HI = 88200 * (100 - TOL_PCT) / 100;
  localparam int FS_HI_HI = 96000 * (100 + TOL_PCT) / 100;
  localparam int FS_LO_MD = 44100 * (100 - TOL_PCT) / 100;
  localparam int FS_HI_MD = 48000 * (100 + TOL_PCT) / 100;
  localparam int FS_LO_LW = 32000 * (100 - TOL_PCT) / 100;
  localparam int FS_HI_LW = 32000 * (100 + TOL_PCT) / 100;

  // Divider ranges forced in receive mode
  localparam logic [1:0] RXA_RANGE_HI = 2'h0;
  localparam logic [1:0] RXA_RANGE_MD = 2'h1;
  localparam logic [1:0] RXA_RANGE_LW = 2'h2;
  localparam logic [1:0] RXB_RANGE    = 2'h0;
  localparam logic       RXB_DOUBLE   = 1'h0;

  // Pin source codes
  typedef enum logic [1:0] {
    SRC_OFF  = 2'b00,
    SRC_PLLA = 2'b01,
    SRC_PLLB = 2'b10,
    SRC_OSC  = 2'b11
  } src_sel_t;

  // Receiver clocking modes
  typedef enum logic [1:0] {
    RXM_NONE = 2'b00,
    RXM_HIGH = 2'b01,
    RXM_MID  = 2'b10,
    RXM_LOW  = 2'b11
  } rx_mode_t;

  // Pin switch states
  typedef enum logic [1:0] {
    SW_RUN    = 2'b00,
    SW_DRAIN  = 2'b01,
    SW_SETTLE = 2'b10
  } sw_state_t;

  // Software settings of one PLL
  typedef struct packed {
    logic              predivSel;
    logic [INT_W-1:0]  intMult;
    logic [FRAC_W-1:0] fracMult;
    logic [1:0]        divRange;
    logic              divDouble;
  } pll_cfg_t;

  // Settings driven to one analog PLL core
  typedef struct packed {
    logic [1:0]               preDivFactor;
    logic [INT_W+FRAC_W-1:0]  ratio;
    logic [4:0]               outDivFactor;
  } pll_drive_t;

endpackage : dual_pll_clk_pkg

// ---- dual_pll_clock_out_select.sv ----
// Dual PLL configuration, receive mode control and clock pin routing
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
module dual_pll_clock_out_select (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  // Register port
  input  wire logic [3:0]                    regAddr,
  input  wire logic [8:0]                    regWrData,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic [8:0]                         regRdData,
  // Clock sources, sampled levels
  input  wire logic                          oscRefClk,
  input  wire logic                          pllAOutClk,
  input  wire logic                          pllBOutClk,
  // Receiver
  input  wire logic [3:0]                    rxIntMult,
  input  wire logic [21:0]                   rxFracMult,
  input  wire logic [16:0]                   rxFsHz,
  input  wire logic                          rxFsValid,
  output dual_pll_clk_pkg::rx_mode_t         rxClkMode,
  // PLL core settings
  output dual_pll_clk_pkg::pll_drive_t       pllADrive,
  output dual_pll_clk_pkg::pll_drive_t       pllBDrive,
  // Master clock pin
  input  wire logic                          masterClkPinIn,
  output logic                               masterClkPinOut,
  output logic                               masterClkPinOeN,
  output logic                               mclkFromPin,
  // Auxiliary clock pin
  output logic                               auxClkPinOut,
  output logic                               auxClkPinOeN
);
  import dual_pll_clk_pkg::*;

  // Register state
  pll_cfg_t  pllACfg_reg;
  pll_cfg_t  pllACfg_next;
  pll_cfg_t  pllBCfg_reg;
  pll_cfg_t  pllBCfg_next;
  src_sel_t  masterSel_reg;
  src_sel_t  masterSel_next;
  src_sel_t  auxSel_reg;
  src_sel_t  auxSel_next;
  logic      rxEn_reg;
  logic      rxEn_next;
  logic [8:0] rdData_reg;
  logic [8:0] rdData_next;

  // Receiver mode state
  rx_mode_t  rxMode_reg;
  rx_mode_t  rxMode_next;
  logic [1:0] rxARange;

  // Pin switch state, index 0 master, 1 aux
  sw_state_t swState_reg [2];
  sw_state_t swState_next [2];
  src_sel_t  curSel_reg [2];
  src_sel_t  curSel_next [2];
  logic      pinOut_reg [2];
  logic      pinOut_next [2];
  logic      pinOeN_reg [2];
  logic      pinOeN_next [2];
  src_sel_t  reqSel [2];
  logic      mclkPin_reg;
  logic      mclkPin_next;

  // Register file writes
  always_comb begin
    pllACfg_next   = pllACfg_reg;
    pllBCfg_next   = pllBCfg_reg;
    masterSel_next = masterSel_reg;
    auxSel_next    = auxSel_reg;
    rxEn_next      = rxEn_reg;
    if (regWr) begin
      case (regAddr)
        OFS_A_K_LO:  pllACfg_next.fracMult[8:0]   = regWrData;
        OFS_A_K_MID: pllACfg_next.fracMult[17:9]  = regWrData;
        OFS_A_N: begin
          pllACfg_next.fracMult[21:18] = regWrData[3:0];
          pllACfg_next.intMult         = regWrData[N_LSB +: INT_W];
        end
        OFS_A_CTRL: begin
          pllACfg_next.predivSel = regWrData[PREDIV_BIT];
          pllACfg_next.divDouble = regWrData[DOUBLE_BIT];
          pllACfg_next.divRange  = regWrData[RANGE_LSB +: 2];
        end
        OFS_B_K_LO:  pllBCfg_next.fracMult[8:0]   = regWrData;
        OFS_B_K_MID: pllBCfg_next.fracMult[17:9]  = regWrData;
        OFS_B_N: begin
          pllBCfg_next.fracMult[21:18] = regWrData[3:0];
          pllBCfg_next.intMult         = regWrData[N_LSB +: INT_W];
        end
        OFS_B_CTRL: begin
          pllBCfg_next.predivSel = regWrData[PREDIV_BIT];
          pllBCfg_next.divDouble = regWrData[DOUBLE_BIT];
          pllBCfg_next.divRange  = regWrData[RANGE_LSB +: 2];
          masterSel_next = src_sel_t'(regWrData[MPIN_LSB +: 2]);
          auxSel_next    = src_sel_t'(regWrData[APIN_LSB +: 2]);
        end
        OFS_MODE:    rxEn_next = regWrData[RXEN_BIT];
        default:     rxEn_next = rxEn_reg;
      endcase
    end
  end

  // Register file reads, zero when no read
  always_comb begin
    rdData_next = 9'h000;
    if (regRd) begin
      case (regAddr)
        OFS_A_K_LO:  rdData_next = pllACfg_reg.fracMult[8:0];
        OFS_A_K_MID: rdData_next = pllACfg_reg.fracMult[17:9];
        OFS_A_N:     rdData_next = {1'b0, pllACfg_reg.intMult,
                                    pllACfg_reg.fracMult[21:18]};
        OFS_A_CTRL:  rdData_next = {4'h0, pllACfg_reg.divRange, 1'b0,
                                    pllACfg_reg.divDouble, pllACfg_reg.predivSel};
        OFS_B_K_LO:  rdData_next = pllBCfg_reg.fracMult[8:0];
        OFS_B_K_MID: rdData_next = pllBCfg_reg.fracMult[17:9];
        OFS_B_N:     rdData_next = {1'b0, pllBCfg_reg.intMult,
                                    pllBCfg_reg.fracMult[21:18]};
        OFS_B_CTRL:  rdData_next = {auxSel_reg, masterSel_reg, pllBCfg_reg.divRange,
                                    1'b0, pllBCfg_reg.divDouble,
                                    pllBCfg_reg.predivSel};
        OFS_MODE:    rdData_next = {8'h00, rxEn_reg};
        OFS_STATUS:  rdData_next = {7'h00, rxMode_reg};
        default:     rdData_next = 9'h000;
      endcase
    end
  end

  // Register file flops, reset for a 12 MHz crystal
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pllACfg_reg   <= '{RST_PREDIV, RST_INT, RST_FRAC, RST_RANGE, RST_DOUBLE};
      pllBCfg_reg   <= '{RST_PREDIV, RST_INT, RST_FRAC, RST_RANGE, RST_DOUBLE};
      masterSel_reg <= src_sel_t'(RST_MPIN);
      auxSel_reg    <= src_sel_t'(RST_APIN);
      rxEn_reg      <= 1'b0;
    end else begin
      pllACfg_reg   <= pllACfg_next;
      pllBCfg_reg   <= pllBCfg_next;
      masterSel_reg <= masterSel_next;
      auxSel_reg    <= auxSel_next;
      rxEn_reg      <= rxEn_next;
    end
  end

  // Read data flop, stands one cycle only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdData_reg <= 9'h000;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  // Classify the incoming sample rate
  always_comb begin
    rxMode_next = rxMode_reg;
    if (!rxEn_reg) begin
      rxMode_next = RXM_NONE;
    end else if (rxFsValid) begin
      if (rxFsHz >= FS_W'(FS_LO_HI) && rxFsHz <= FS_W'(FS_HI_HI)) begin
        rxMode_next = RXM_HIGH;
      end else if (rxFsHz >= FS_W'(FS_LO_MD) && rxFsHz <= FS_W'(FS_HI_MD)) begin
        rxMode_next = RXM_MID;
      end else if (rxFsHz >= FS_W'(FS_LO_LW) && rxFsHz <= FS_W'(FS_HI_LW)) begin
        rxMode_next = RXM_LOW;
      end else begin
        rxMode_next = RXM_NONE;
      end
    end
  end

  // PLL A divider range per receiver mode
  always_comb begin
    case (rxMode_reg)
      RXM_HIGH: rxARange = RXA_RANGE_HI;
      RXM_MID:  rxARange = RXA_RANGE_MD;
      RXM_LOW:  rxARange = RXA_RANGE_LW;
      default:  rxARange = pllACfg_reg.divRange;
    endcase
  end

  // Receiver mode flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxMode_reg <= RXM_NONE;
    end else begin
      rxMode_reg <= rxMode_next;
    end
  end

  // PLL A, multipliers owned by the receiver in receive mode
  pll_cfg_path u_pll_a (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .cfgUser  (pllACfg_reg),
    .multOwn  (rxEn_reg),
    .rxInt    (rxIntMult),
    .rxFrac   (rxFracMult),
    .divOwn   (rxEn_reg),
    .rxRange  (rxARange),
    .rxDouble (pllACfg_reg.divDouble),
    .drive    (pllADrive)
  );

  // PLL B, output divider fixed in receive mode
  pll_cfg_path u_pll_b (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .cfgUser  (pllBCfg_reg),
    .multOwn  (1'b0),
    .rxInt    (pllBCfg_reg.intMult),
    .rxFrac   (pllBCfg_reg.fracMult),
    .divOwn   (rxEn_reg),
    .rxRange  (RXB_RANGE),
    .rxDouble (RXB_DOUBLE),
    .drive    (pllBDrive)
  );

  // Requested source per pin
  assign reqSel[0] = masterSel_reg;
  assign reqSel[1] = auxSel_reg;

  // Glitch free source switch, one per pin
  for (genvar g = 0; g < 2; g++) begin : g_pin
    logic srcLvl;

    // Level of the currently selected source
    always_comb begin
      case (curSel_reg[g])
        SRC_PLLA: srcLvl = pllAOutClk;
        SRC_PLLB: srcLvl = pllBOutClk;
        SRC_OSC:  srcLvl = oscRefClk;
        default:  srcLvl = 1'b0;
      endcase
    end

    // Drain old source low, then wait for new source low
    always_comb begin
      swState_next[g] = swState_reg[g];
      curSel_next[g]  = curSel_reg[g];
      pinOut_next[g]  = srcLvl;
      case (swState_reg[g])
        SW_RUN: begin
          if (reqSel[g] != curSel_reg[g]) begin
            swState_next[g] = SW_DRAIN;
          end
        end
        SW_DRAIN: begin
          if (!srcLvl) begin
            curSel_next[g]  = reqSel[g];
            swState_next[g] = SW_SETTLE;
          end
        end
        SW_SETTLE: begin
          pinOut_next[g] = 1'b0;
          if (!srcLvl) begin
            swState_next[g] = SW_RUN;
          end
        end
        default: swState_next[g] = SW_RUN;
      endcase
      pinOeN_next[g] = (curSel_next[g] == SRC_OFF);
    end

    // Pin switch flops, reset selections already in place
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        swState_reg[g] <= SW_RUN;
        curSel_reg[g]  <= (g == 0) ? src_sel_t'(RST_MPIN) : src_sel_t'(RST_APIN);
        pinOut_reg[g]  <= 1'b0;
        pinOeN_reg[g]  <= (g == 0) ? (RST_MPIN == SRC_OFF) : (RST_APIN == SRC_OFF);
      end else begin
        swState_reg[g] <= swState_next[g];
        curSel_reg[g]  <= curSel_next[g];
        pinOut_reg[g]  <= pinOut_next[g];
        pinOeN_reg[g]  <= pinOeN_next[g];
      end
    end
  end

  // Master pin as input feeds the internal clock
  always_comb begin
    mclkPin_next = (curSel_reg[0] == SRC_OFF) ? masterClkPinIn : 1'b0;
  end

  // Input capture flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mclkPin_reg <= 1'b0;
    end else begin
      mclkPin_reg <= mclkPin_next;
    end
  end

  // Outputs straight from flops
  assign regRdData       = rdData_reg;
  assign rxClkMode       = rxMode_reg;
  assign masterClkPinOut = pinOut_reg[0];
  assign masterClkPinOeN = pinOeN_reg[0];
  assign auxClkPinOut    = pinOut_reg[1];
  assign auxClkPinOeN    = pinOeN_reg[1];
  assign mclkFromPin     = mclkPin_reg;

endmodule : dual_pll_clock_out_select

// ---- dual_pll_clock_out_select_monitor.sv ----
// Port checker for the dual PLL clock block
`timescale 1ns/100ps
module dual_pll_clock_out_select_monitor (
  // Clock and reset
  input wire logic                         sys_clk,
  input wire logic                         rst,
  // Register port
  input wire logic [3:0]                   regAddr,
  input wire logic                         regRd,
  input wire logic [8:0]                   regRdData,
  // Receiver and PLL settings
  input wire logic [3:0]                   rxIntMult,
  input wire logic [21:0]                  rxFracMult,
  input wire logic [16:0]                  rxFsHz,
  input wire logic                         rxFsValid,
  input wire dual_pll_clk_pkg::rx_mode_t   rxClkMode,
  input wire dual_pll_clk_pkg::pll_drive_t pllADrive,
  input wire dual_pll_clk_pkg::pll_drive_t pllBDrive,
  // Sources and pins
  input wire logic                         oscRefClk,
  input wire logic                         pllAOutClk,
  input wire logic                         pllBOutClk,
  input wire logic                         masterClkPinIn,
  input wire logic                         mclkFromPin,
  input wire logic                         auxClkPinOut
);
  import dual_pll_clk_pkg::*;
  logic inHi;
  logic inLw;
  logic inMd;
  // Rate windows of the receiver modes
  assign inHi = rxFsHz >= 17'h15516 && rxFsHz <= 17'h17ac0;
  assign inMd = rxFsHz >= 17'h0aa8b && rxFsHz <= 17'h0bd60;
  assign inLw = rxFsHz >= 17'h07bc0 && rxFsHz <= 17'h07e40;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  // Register read path
  a_rd_idle: assert property (
    !$past(regRd) |-> regRdData == 9'h000) else $error("read data not idle");
  a_rd_unmapped: assert property (
    $past(regRd) && $past(regAddr) > 4'h9 |-> regRdData == 9'h000)
    else $error("unmapped read not zero");
  a_status_rd: assert property (
    $past(regRd) && $past(regAddr) == 4'h9 |-> regRdData == {7'h00, $past(rxClkMode)})
    else $error("status read wrong");
  // Receiver rate classification
  a_rx_high: assert property (
    rxFsValid && inHi |=> rxClkMode inside {RXM_HIGH, RXM_NONE})
    else $error("high rate misclassified");
  a_rx_low: assert property (
    rxFsValid && inLw |=> rxClkMode inside {RXM_LOW, RXM_NONE})
    else $error("low rate misclassified");
  a_rx_none: assert property (
    rxFsValid && !(inHi || inMd || inLw) |=> rxClkMode == RXM_NONE)
    else $error("rate outside windows accepted");
  // Receive mode overrides
  a_rxa_ratio: assert property (
    rxClkMode != RXM_NONE [*3] |-> pllADrive.ratio == {$past(rxIntMult), $past(rxFracMult)})
    else $error("PLL A ratio not from receiver");
  a_rxa_high: assert property (
    rxClkMode == RXM_HIGH [*3] |-> pllADrive.outDivFactor inside {5'h02, 5'h04})
    else $error("PLL A divider wrong in high mode");
  a_rxb_fixed: assert property (
    rxClkMode != RXM_NONE [*3] |-> pllBDrive.outDivFactor == 5'h02)
    else $error("PLL B divider not ignored");
  // Pin routing
  a_aux_source: assert property (
    auxClkPinOut |-> $past(oscRefClk) || $past(pllAOutClk) || $past(pllBOutClk))
    else $error("aux pin high without source");
  a_aux_runt: assert property (
    $rose(auxClkPinOut) |=> auxClkPinOut) else $error("runt pulse on aux pin");
  a_mclk_in: assert property (
    mclkFromPin |-> $past(masterClkPinIn)) else $error("pin input path wrong");
endmodule : dual_pll_clock_out_select_monitor

// ---- pll_cfg_path.sv ----
// One PLL configuration path, identical for both PLLs
`timescale 1ns/100ps
module pll_cfg_path (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  // Software settings
  input  wire dual_pll_clk_pkg::pll_cfg_t    cfgUser,
  // Receiver overrides
  input  wire logic                          multOwn,
  input  wire logic [3:0]                    rxInt,
  input  wire logic [21:0]                   rxFrac,
  input  wire logic                          divOwn,
  input  wire logic [1:0]                    rxRange,
  input  wire logic                          rxDouble,
  // Core settings
  output dual_pll_clk_pkg::pll_drive_t       drive
);
  import dual_pll_clk_pkg::*;

  pll_cfg_t   eff;
  logic [4:0] baseDiv;
  pll_drive_t drive_reg;
  pll_drive_t drive_next;

  // Pick effective settings and decode them
  always_comb begin
    eff = cfgUser;
    if (multOwn) begin
      eff.intMult  = rxInt;
      eff.fracMult = rxFrac;
    end
    if (divOwn) begin
      eff.divRange  = rxRange;
      eff.divDouble = rxDouble;
    end
    case (eff.divRange)
      2'h0:    baseDiv = DIV_R0;
      2'h1:    baseDiv = DIV_R1;
      2'h2:    baseDiv = DIV_R2;
      default: baseDiv = DIV_R3;
    endcase
    drive_next.preDivFactor = eff.predivSel ? 2'h2 : 2'h1;
    drive_next.ratio        = {eff.intMult, eff.fracMult};
    drive_next.outDivFactor = eff.divDouble ? {baseDiv[3:0], 1'b0} : baseDiv;
  end

  // Register the decoded settings
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      drive_reg <= '0;
    end else begin
      drive_reg <= drive_next;
    end
  end

  assign drive = drive_reg;

endmodule : pll_cfg_path

// ---- tb_dual_pll_clock_out_select.sv ----
// Self-checking bench for the dual PLL clock block
`timescale 1ns/100ps
module tb_dual_pll_clock_out_select;
  import dual_pll_clk_pkg::*;
  // Register reset values, last one unmapped
  localparam logic [8:0] RST_VAL [11] = '{9'h121, 9'h17e, 9'h07d, 9'h010, 9'h121,
    9'h17e, 9'h07d, 9'h190, 9'h000, 9'h000, 9'h000};
  // Divider rows: offset, data, output factor
  localparam logic [17:0] DIV_ROWS [8] = '{{4'h3, 9'h000, 5'h02}, {4'h3, 9'h009, 5'h04},
    {4'h3, 9'h012, 5'h10}, {4'h3, 9'h01b, 5'h18}, {4'h7, 9'h183, 5'h04},
    {4'h7, 9'h18a, 5'h08}, {4'h7, 9'h191, 5'h08}, {4'h7, 9'h198, 5'h0c}};
  // Receiver rows: rate, mode, PLL A factor
  localparam logic [23:0] RX_ROWS [6] = '{{17'h17ac0, 2'h1, 5'h04},
    {17'h15515, 2'h0, 5'h18}, {17'h0bd60, 2'h2, 5'h08}, {17'h0aa8a, 2'h0, 5'h18},
    {17'h07bc0, 2'h3, 5'h10}, {17'h07e41, 2'h0, 5'h18}};
  logic        sys_clk    = 1'b0;
  logic        rst        = 1'b1;
  logic [3:0]  regAddr    = 4'h0;
  logic [8:0]  regWrData  = 9'h000;
  logic        regWr      = 1'b0;
  logic        regRd      = 1'b0;
  logic [3:0]  rxIntMult  = 4'h8;
  logic [21:0] rxFracMult = 22'h2b3333;
  logic [16:0] rxFsHz     = 17'h00000;
  logic        rxFsValid  = 1'b0;
  logic [8:0]  regRdData;
  rx_mode_t    rxClkMode;
  pll_drive_t  pllADrive;
  pll_drive_t  pllBDrive;
  logic        oscRefClk, pllAOutClk, pllBOutClk, masterClkPinIn, mclkFromPin;
  logic        masterClkPinOut, masterClkPinOeN, auxClkPinOut, auxClkPinOeN;
  logic [3:0]  pv;
  int          nMismatch  = 0;
  int          testsRun   = 0;
  // Clock
  always #20 sys_clk = ~sys_clk;
  // Block and far side
  dual_pll_clock_out_select i_dual_pll_clock_out_select (.sys_clk, .rst, .regAddr,
    .regWrData, .regWr, .regRd, .regRdData, .oscRefClk, .pllAOutClk, .pllBOutClk,
    .rxIntMult, .rxFracMult, .rxFsHz, .rxFsValid, .rxClkMode, .pllADrive, .pllBDrive,
    .masterClkPinIn, .masterClkPinOut, .masterClkPinOeN, .mclkFromPin, .auxClkPinOut,
    .auxClkPinOeN);
  clk_src_model i_clk_src_model (.sys_clk, .rst, .pinOeN(masterClkPinOeN),
    .pinOut(masterClkPinOut), .oscLvl(oscRefClk), .pllALvl(pllAOutClk),
    .pllBLvl(pllBOutClk), .pinLvl(masterClkPinIn));
  task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [8:0] d);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge sys_clk);
    regWr     <= 1'b0;
  endtask : wr
  task automatic rc(input logic [3:0] a, input logic [8:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd   <= 1'b0;
    @(negedge sys_clk);
    chk("regRdData", exp, regRdData);
  endtask : rc
  task automatic mult(input logic [3:0] b, input logic [3:0] n, input logic [21:0] k);
    wr(b, k[8:0]);
    wr(b + 4'h1, k[17:9]);
    wr(b + 4'h2, {1'b0, n, k[21:18]});
  endtask : mult
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : settle
  task automatic do_reset;
    rst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk("masterClkPinOeN", 1'b1, masterClkPinOeN);
    chk("auxClkPinOeN", 1'b0, auxClkPinOeN);
    rst <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk("pllADrive", {2'h1, 26'h1f6fd21, 5'h08}, pllADrive);
    chk("pllBDrive", {2'h1, 26'h1f6fd21, 5'h08}, pllBDrive);
    for (int i = 0; i < 11; i++) rc(4'(i), RST_VAL[i]);
    $display("reset test done");
  endtask : do_reset
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  // Watchdog
  initial begin
    repeat (5000) @(posedge sys_clk);
    nMismatch++;
    $display("watchdog expired");
    report_and_stop();
  end
  // Main sequence
  initial begin
    do_reset();
    mult(4'h0, 4'h8, 22'h0c49ba);
    mult(4'h4, 4'h7, 22'h21b089);
    rc(4'h2, 9'h083);
    foreach (DIV_ROWS[i]) begin
      wr(DIV_ROWS[i][17:14], DIV_ROWS[i][13:5]);
      settle();
      chk("pll drive", {DIV_ROWS[i][5] ? 2'h2 : 2'h1,
        DIV_ROWS[i][17:14] == 4'h3 ? 26'h20c49ba : 26'h1e1b089, DIV_ROWS[i][4:0]},
        DIV_ROWS[i][17:14] == 4'h3 ? pllADrive : pllBDrive);
    end
    $display("divider test done");
    for (int s = 0; s < 4; s++) begin
      wr(4'h7, {2'(3 - s), 2'(s), 5'h10});
      repeat (30) @(posedge sys_clk);
      @(negedge sys_clk);
      pv = {oscRefClk, pllBOutClk, pllAOutClk, masterClkPinIn};
      repeat (12) begin
        @(negedge sys_clk);
        chk("master pin", pv[s], s == 0 ? mclkFromPin : masterClkPinOut);
        chk("master oe", s == 0, masterClkPinOeN);
        chk("aux oe", s == 3, auxClkPinOeN);
        if (s != 3) chk("aux pin", pv[3 - s], auxClkPinOut);
        pv = {oscRefClk, pllBOutClk, pllAOutClk, masterClkPinIn};
      end
    end
    $display("pin test done");
    // Host loads the reference and equal pre-dividers, then enables reception
    mult(4'h4, 4'h7, 22'h36fd21);
    wr(4'h3, 9'h01a);
    wr(4'h7, 9'h19a);
    wr(4'h8, 9'h001);
    foreach (RX_ROWS[i]) begin
      @(posedge sys_clk);
      rxFsHz    <= RX_ROWS[i][23:7];
      rxFsValid <= 1'b1;
      rxFracMult <= rxFracMult + 22'h000111;
      @(posedge sys_clk);
      rxFsValid <= 1'b0;
      settle();
      chk("rxClkMode", RX_ROWS[i][6:5], rxClkMode);
      chk("pllADrive", {2'h1, rxIntMult, rxFracMult, RX_ROWS[i][4:0]}, pllADrive);
      chk("pllB factor", 5'h02, pllBDrive.outDivFactor);
      rc(4'h9, {7'h00, RX_ROWS[i][6:5]});
    end
    wr(4'h8, 9'h000);
    settle();
    chk("rxClkMode", 2'h0, rxClkMode);
    chk("pllADrive", {2'h1, 26'h20c49ba, 5'h18}, pllADrive);
    $display("receiver test done");
    wr(4'h9, 9'h1ff);
    wr(4'hc, 9'h1ff);
    rc(4'h9, 9'h000);
    rc(4'hc, 9'h000);
    $display("refusal test done");
    @(posedge sys_clk);
    do_reset();
    report_and_stop();
  end
endmodule : tb_dual_pll_clock_out_select
bind dual_pll_clock_out_select dual_pll_clock_out_select_monitor
  i_dual_pll_clock_out_select_monitor (.sys_clk, .rst, .regAddr, .regRd, .regRdData,
  .rxIntMult, .rxFracMult, .rxFsHz, .rxFsValid, .rxClkMode, .pllADrive, .pllBDrive,
  .oscRefClk, .pllAOutClk, .pllBOutClk, .masterClkPinIn, .mclkFromPin, .auxClkPinOut);
